// ### mcu_program_sequencer.sv
// Four-phase program sequencer with return stack and table reads
// Overview of operation
// - Four phases per instruction cycle
// - T1 increments counter and fetches next word
// - Fetch overlaps execution of current word
// - Counter-changing instructions take one extra cycle
// - Taken skip replaces prefetched word by dummy
// - Counter: bank bit, bits 12-8, low byte
// - Only the low byte is software visible
// - Low-byte write jumps within page, adds dummy
// - Call and interrupt push; returns pop
// - Stack and pointer are not software visible
// - Reset leaves the stack empty at top
// - Full stack holds interrupt pending until return
// - Call on full stack still proceeds
// - ALU writes destination and updates zero; carry only on add and subtract
// - Program memory is 16K words of 16
// - Execution starts at address zero
// - Table address comes from two pointers
// - Table low byte to register, high to latch
// - Extended table read reaches other sectors
// - Table reads take two instruction cycles
`timescale 1ns/1ns
module mcu_program_sequencer (
  input wire logic clk,
  input wire logic reset_n,
  input wire seq_pkg::reg_req_t reg_req,
  output logic [seq_pkg::DATA_W-1:0] reg_rdata,
  output logic [seq_pkg::PC_W-1:0] pm_addr,
  input wire logic [seq_pkg::WORD_W-1:0] pm_data,
  output seq_pkg::dm_req_t dm_req,
  input wire logic [seq_pkg::DATA_W-1:0] dm_rdata,
  input wire logic int_req,
  output logic int_ack
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] phase;
    logic started;
    logic [seq_pkg::PC_W-1:0] pc;
    logic [seq_pkg::WORD_W-1:0] ir;
    logic ir_valid;
    logic tab_busy;
    logic [seq_pkg::DADDR_W-1:0] tab_dst;
    logic [seq_pkg::DATA_W-1:0] acc;
    logic carry;
    logic zero;
    logic [seq_pkg::DATA_W-1:0] tbl_low;
    logic [seq_pkg::DATA_W-1:0] tbl_high;
    logic [seq_pkg::DATA_W-1:0] tbl_latch;
    logic bank_sel;
    logic int_en;
    logic int_pend;
    logic pcl_pend;
    logic [seq_pkg::DATA_W-1:0] pcl_val;
    logic [seq_pkg::STACK_DEPTH-1:0][seq_pkg::PC_W-1:0] stack;
    logic [seq_pkg::SP_W-1:0] sp;
    logic [seq_pkg::SP_W:0] level;
    logic [seq_pkg::DATA_W-1:0] rdata;
    logic [seq_pkg::PC_W-1:0] pm_addr;
    seq_pkg::dm_req_t dm;
    logic int_ack;
  } state_t;

  state_t s;
  state_t next_s;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address of the word that was prefetched and is being thrown away
  function automatic logic [seq_pkg::PC_W-1:0] ret_addr(
    input logic [seq_pkg::PC_W-1:0] pc);
    ret_addr = pc - seq_pkg::PC_STEP;
  endfunction : ret_addr

  // Data address of an operand; only store reaches beyond sector 0
  function automatic logic [seq_pkg::DADDR_W-1:0] daddr(
    input logic [seq_pkg::WORD_W-1:0] ir);
    if (seq_pkg::op_t'(ir[seq_pkg::OP_MSB:seq_pkg::OP_LSB])
        == seq_pkg::OP_STORE) begin
      daddr = ir[seq_pkg::DADDR_W-1:0];
    end else begin
      daddr = {2'h0, ir[seq_pkg::DATA_W-1:0]};
    end
  endfunction : daddr

  // Result in the low byte, carry (no borrow for subtract) on top
  function automatic logic [8:0] alu(input seq_pkg::alu_fn_t fn,
    input logic [7:0] a, input logic [7:0] b);
    logic [8:0] r;
    r = 9'h000;
    unique case (fn)
      seq_pkg::ALU_ADD: r = {1'b0, a} + {1'b0, b};
      seq_pkg::ALU_SUB: begin
        r = {1'b0, a} - {1'b0, b};
        r[8] = ~r[8];
      end
      seq_pkg::ALU_AND: r = {1'b0, a & b};
      seq_pkg::ALU_OR: r = {1'b0, a | b};
      seq_pkg::ALU_XOR: r = {1'b0, a ^ b};
      seq_pkg::ALU_INC: r = {1'b0, b} + 9'h001;
      seq_pkg::ALU_DEC: r = {1'b0, b} - 9'h001;
      seq_pkg::ALU_MOV: r = {1'b0, b};
    endcase
    alu = r;
  endfunction : alu

  seq_pkg::op_t op;
  logic t4_exec;
  logic [seq_pkg::PC_W-1:0] pc_ret;
  assign op = seq_pkg::op_t'(s.ir[seq_pkg::OP_MSB:seq_pkg::OP_LSB]);
  assign t4_exec = s.phase == seq_pkg::PH_T4 && s.ir_valid && !s.tab_busy;
  assign pc_ret = ret_addr(s.pc);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // One evaluation per clock; execution happens only in the T4 slot
  always_comb begin
    logic [8:0] res;
    logic flush;
    logic push_en;
    logic pop_en;
    logic flow;
    logic [seq_pkg::PC_W-1:0] push_val;
    res = 9'h000;
    flush = 1'b0;
    push_en = 1'b0;
    pop_en = 1'b0;
    flow = 1'b0;
    push_val = s.pc;
    next_s = s;
    next_s.dm.we = 1'b0;
    next_s.int_ack = 1'b0;
    next_s.rdata = 8'h00;
    next_s.phase = s.phase + seq_pkg::PH_STEP;

    // T1: step the counter and fetch, or fetch the table word
    if (s.phase == seq_pkg::PH_T1) begin
      next_s.started = 1'b1;
      if (s.tab_busy) begin
        next_s.pm_addr = {s.tbl_high[5:0], s.tbl_low};
      end else begin
        next_s.pm_addr = s.pc;
        next_s.pc = s.pc + seq_pkg::PC_STEP;
      end
    end

    // T2: present the operand address to data memory
    if (s.phase == seq_pkg::PH_T2) begin
      next_s.dm.addr = s.tab_busy ? s.tab_dst : daddr(s.ir);
    end

    // T4: finish a table transfer or execute the held word
    if (s.phase == seq_pkg::PH_T4) begin
      if (s.tab_busy) begin
        // Second cycle of a table read; the held word waits
        next_s.dm = '{addr: s.tab_dst, wdata: pm_data[7:0], we: 1'b1};
        next_s.tbl_latch = pm_data[15:8];
        next_s.tab_busy = 1'b0;
      end else begin
        next_s.ir = pm_data;
        next_s.ir_valid = 1'b1;
        if (s.ir_valid) begin
          unique case (op)
            seq_pkg::OP_ALU: begin
              res = alu(seq_pkg::alu_fn_t'(
                s.ir[seq_pkg::FN_MSB:seq_pkg::FN_LSB]), s.acc, dm_rdata);
              if (s.ir[seq_pkg::DEST_MEM]) begin
                next_s.dm = '{addr: daddr(s.ir), wdata: res[7:0], we: 1'b1};
              end else begin
                next_s.acc = res[7:0];
              end
              next_s.zero = res[7:0] == 8'h00;
              if (s.ir[seq_pkg::FN_MSB:seq_pkg::FN_LSB] <= 3'h1) begin
                next_s.carry = res[8];
              end
            end
            seq_pkg::OP_GOTO: begin
              next_s.pc = {s.bank_sel, s.ir[seq_pkg::TGT_MSB:0]};
              flush = 1'b1;
              flow = 1'b1;
            end
            seq_pkg::OP_CALL: begin
              push_en = 1'b1;
              push_val = pc_ret;
              next_s.pc = {s.bank_sel, s.ir[seq_pkg::TGT_MSB:0]};
              flush = 1'b1;
              flow = 1'b1;
            end
            seq_pkg::OP_RET: begin
              pop_en = 1'b1;
              next_s.pc = s.stack[s.sp - 1'b1];
              if (s.ir[seq_pkg::INTERRUPT_RETURN_BIT]) begin
                next_s.int_en = 1'b1;
              end
              flush = 1'b1;
              flow = 1'b1;
            end
            seq_pkg::OP_SKZ: begin
              if (dm_rdata == 8'h00) begin
                flush = 1'b1;
              end
            end
            seq_pkg::OP_TAB: begin
              next_s.tab_busy = 1'b1;
              next_s.tab_dst = s.ir[seq_pkg::TAB_EXT] ?
                s.ir[seq_pkg::DADDR_W-1:0] : daddr(s.ir);
              flow = 1'b1;
            end
            seq_pkg::OP_STORE: begin
              if (daddr(s.ir) == seq_pkg::PCL_DADDR) begin
                next_s.pc[7:0] = s.acc;
                flush = 1'b1;
                flow = 1'b1;
              end else begin
                next_s.dm = '{addr: daddr(s.ir), wdata: s.acc, we: 1'b1};
              end
            end
            seq_pkg::OP_LOADI: next_s.acc = s.ir[7:0];
          endcase
        end
        // Software low-byte write lands here so no executing word is lost
        if (s.pcl_pend && !flow) begin
          next_s.pc[7:0] = s.pcl_val;
          next_s.pcl_pend = 1'b0;
          flush = 1'b1;
          flow = 1'b1;
        end
        // Interrupt waits while the stack is full or a branch is in flight
        if (s.int_pend && s.int_en && s.level != seq_pkg::STACK_FULL
            && !flow && !flush) begin
          push_en = 1'b1;
          push_val = next_s.pc - seq_pkg::PC_STEP;
          next_s.pc = seq_pkg::INT_VECTOR;
          next_s.int_en = 1'b0;
          next_s.int_ack = 1'b1;
          flush = 1'b1;
        end
        if (flush) begin
          next_s.ir_valid = 1'b0;
        end
      end
    end

    // Circular stack: overflow overwrites the oldest entry
    if (push_en) begin
      next_s.stack[s.sp] = push_val;
      next_s.sp = s.sp + 1'b1;
      if (s.level != seq_pkg::STACK_FULL) begin
        next_s.level = s.level + 1'b1;
      end
    end
    if (pop_en) begin
      next_s.sp = s.sp - 1'b1;
      if (s.level != '0) begin
        next_s.level = s.level - 1'b1;
      end
    end

    // Request latch: a new request beats the clear from acknowledge
    next_s.int_pend = (s.int_pend & ~next_s.int_ack) | int_req;

    // Register port; stack and pointer have no address at all
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        seq_pkg::REG_PC_LOW: next_s.rdata = s.pc[7:0];
        seq_pkg::REG_TBL_LOW: next_s.rdata = s.tbl_low;
        seq_pkg::REG_TBL_HIGH: next_s.rdata = s.tbl_high;
        seq_pkg::REG_TBL_LATCH: next_s.rdata = s.tbl_latch;
        seq_pkg::REG_CONTROL: begin
          next_s.rdata[seq_pkg::CTRL_INT_EN] = s.int_en;
          next_s.rdata[seq_pkg::CTRL_BANK] = s.bank_sel;
        end
        seq_pkg::REG_STATUS: begin
          next_s.rdata[seq_pkg::STAT_CARRY] = s.carry;
          next_s.rdata[seq_pkg::STAT_ZERO] = s.zero;
          next_s.rdata[seq_pkg::STAT_PEND] = s.int_pend;
        end
        seq_pkg::REG_ACC: next_s.rdata = s.acc;
        default: next_s.rdata = 8'h00;
      endcase
    end
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        seq_pkg::REG_PC_LOW: begin
          next_s.pcl_pend = 1'b1;
          next_s.pcl_val = reg_req.wdata;
        end
        seq_pkg::REG_TBL_LOW: next_s.tbl_low = reg_req.wdata;
        seq_pkg::REG_TBL_HIGH: next_s.tbl_high = reg_req.wdata;
        seq_pkg::REG_TBL_LATCH: next_s.tbl_latch = reg_req.wdata;
        seq_pkg::REG_CONTROL: begin
          next_s.int_en = reg_req.wdata[seq_pkg::CTRL_INT_EN];
          next_s.bank_sel = reg_req.wdata[seq_pkg::CTRL_BANK];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Stack empty and at its top, counter at the reset vector
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.pc <= seq_pkg::RESET_VECTOR;
      s.sp <= '0;
      s.level <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign pm_addr = s.pm_addr;
  assign dm_req = s.dm;
  assign int_ack = s.int_ack;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_phase_wraps: assert property (
    @(posedge clk) disable iff (!reset_n)
    s.phase == seq_pkg::PH_T4 |=> s.phase == seq_pkg::PH_T1)
    else $error("phase did not wrap to T1");

  a_pc_fetch: assert property (
    @(posedge clk) disable iff (!reset_n)
    s.phase == seq_pkg::PH_T1 && !s.tab_busy
    |=> s.pc == $past(s.pc) + seq_pkg::PC_STEP && pm_addr == $past(s.pc))
    else $error("T1 did not fetch and step counter");

  a_reset_fetch: assert property (
    @(posedge clk) disable iff (!reset_n)
    !s.started && s.phase == seq_pkg::PH_T1
    |=> pm_addr == seq_pkg::RESET_VECTOR)
    else $error("first fetch not at reset vector");

  a_goto_dummy: assert property (
    @(posedge clk) disable iff (!reset_n)
    t4_exec && op == seq_pkg::OP_GOTO |=> !s.ir_valid [*4])
    else $error("jump did not insert a dummy cycle");

  a_skip_drop: assert property (
    @(posedge clk) disable iff (!reset_n)
    t4_exec && op == seq_pkg::OP_SKZ && dm_rdata == 8'h00 && !s.pcl_pend
    |=> !s.ir_valid && s.pc == $past(s.pc))
    else $error("taken skip kept prefetched word");

  a_call_push: assert property (
    @(posedge clk) disable iff (!reset_n)
    t4_exec && op == seq_pkg::OP_CALL
    |=> s.stack[$past(s.sp)] == $past(pc_ret) && s.sp == $past(s.sp) + 1'b1)
    else $error("call did not push return address");

  a_full_holds: assert property (
    @(posedge clk) disable iff (!reset_n)
    s.phase == seq_pkg::PH_T4 && s.level == seq_pkg::STACK_FULL
    |=> !int_ack)
    else $error("interrupt taken with full stack");

  a_table_two: assert property (
    @(posedge clk) disable iff (!reset_n)
    t4_exec && op == seq_pkg::OP_TAB |=> s.tab_busy [*4] ##1 !s.tab_busy)
    else $error("table read not two cycles");

  a_table_latch: assert property (
    @(posedge clk) disable iff (!reset_n)
    s.tab_busy && s.phase == seq_pkg::PH_T4
    |=> s.tbl_latch == $past(pm_data[15:8]) && dm_req.we
        && dm_req.wdata == $past(pm_data[7:0]))
    else $error("table bytes not delivered");

  a_pcl_page: assert property (
    @(posedge clk) disable iff (!reset_n)
    s.phase == seq_pkg::PH_T4 && s.pcl_pend && !s.tab_busy && !s.ir_valid
    |=> s.pc[13:8] == $past(s.pc[13:8]) && s.pc[7:0] == $past(s.pcl_val))
    else $error("low byte jump left its page");
endmodule : mcu_program_sequencer

// ### seq_far_memory.sv
// Far-side model: program memory and data register file
`timescale 1ns/1ns
module seq_far_memory (
  input wire logic clk,
  input wire logic slow,
  input wire logic [13:0] pm_addr,
  output logic [15:0] pm_data,
  input wire seq_pkg::dm_req_t dm_req,
  output logic [7:0] dm_rdata
);
  logic [15:0] pmem [0:16383];
  logic [7:0] dmem [0:1023];
  logic [15:0] lag1;
  logic [15:0] lag2;

  // Slow mode answers two clocks late, still inside the T4 deadline
  always @(posedge clk) begin
    lag1 <= pmem[pm_addr];
    lag2 <= lag1;
  end
  assign pm_data = slow ? lag2 : pmem[pm_addr];

  // Register file reads at once; the sequencer samples it at T4
  assign dm_rdata = dmem[dm_req.addr];
  always @(posedge clk) begin
    if (dm_req.we) dmem[dm_req.addr] <= dm_req.wdata;
  end
endmodule : seq_far_memory

// ### seq_pkg.sv
// Shared constants and types for the program sequencer
package seq_pkg;
  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int PC_W = 14;
  localparam int WORD_W = 16;
  localparam int DATA_W = 8;
  localparam int DADDR_W = 10;
  localparam int STACK_DEPTH = 8; // Power of two so the pointer wraps
  localparam int SP_W = $clog2(STACK_DEPTH);
  localparam logic [SP_W:0] STACK_FULL = (SP_W+1)'(STACK_DEPTH);

  // ----------------------------------------------------------------
  // Vectors and phases
  // ----------------------------------------------------------------
  localparam logic [PC_W-1:0] RESET_VECTOR = 14'h0000;
  localparam logic [PC_W-1:0] INT_VECTOR = 14'h0004;
  localparam logic [PC_W-1:0] PC_STEP = 14'h0001;
  localparam logic [1:0] PH_T1 = 2'h0;
  localparam logic [1:0] PH_T2 = 2'h1;
  localparam logic [1:0] PH_T4 = 2'h3;
  localparam logic [1:0] PH_STEP = 2'h1;

  // ----------------------------------------------------------------
  // Register port map and fields
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_PC_LOW = 3'h0;
  localparam logic [2:0] REG_TBL_LOW = 3'h1;
  localparam logic [2:0] REG_TBL_HIGH = 3'h2;
  localparam logic [2:0] REG_TBL_LATCH = 3'h3;
  localparam logic [2:0] REG_CONTROL = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;
  localparam logic [2:0] REG_ACC = 3'h6;
  localparam int CTRL_INT_EN = 0;
  localparam int CTRL_BANK = 1;
  localparam int STAT_CARRY = 0;
  localparam int STAT_ZERO = 1;
  localparam int STAT_PEND = 2;
  localparam logic [DADDR_W-1:0] PCL_DADDR = 10'h006;

  // ----------------------------------------------------------------
  // Instruction word layout
  // ----------------------------------------------------------------
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 13;
  localparam int FN_MSB = 12;
  localparam int FN_LSB = 10;
  localparam int TGT_MSB = 12;
  localparam int DEST_MEM = 8;
  localparam int TAB_EXT = 12;
  localparam int INTERRUPT_RETURN_BIT = 0;

  typedef enum logic [2:0] {
    OP_ALU, OP_GOTO, OP_CALL, OP_RET, OP_SKZ, OP_TAB, OP_STORE, OP_LOADI
  } op_t;

  typedef enum logic [2:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_INC, ALU_DEC, ALU_MOV
  } alu_fn_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [DADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
  } dm_req_t;
endpackage : seq_pkg

// ### test_mcu_program_sequencer.sv
// Self-checking bench for the program sequencer
`timescale 1ns/1ns
module test_mcu_program_sequencer;
  logic clk;
  logic reset_n;
  logic int_req;
  logic slow;
  logic acked;
  seq_pkg::reg_req_t rq;
  logic [7:0] reg_rdata;
  logic [13:0] pm_addr;
  logic [15:0] pm_data;
  seq_pkg::dm_req_t dm_req;
  logic [7:0] dm_rdata;
  logic int_ack;
  logic [13:0] trace [0:63];
  int ecnt;
  int bad_count;
  int num_checks;

  mcu_program_sequencer i_mcu_program_sequencer (
    .clk(clk), .reset_n(reset_n), .reg_req(rq), .reg_rdata(reg_rdata),
    .pm_addr(pm_addr), .pm_data(pm_data), .dm_req(dm_req),
    .dm_rdata(dm_rdata), .int_req(int_req), .int_ack(int_ack));
  seq_far_memory i_seq_far_memory (.clk(clk), .slow(slow),
    .pm_addr(pm_addr), .pm_data(pm_data), .dm_req(dm_req),
    .dm_rdata(dm_rdata));

  // Free-running 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Edge count since release; fetch address recorded after each T1 edge of the first 64 cycles
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) ecnt <= 0;
    else ecnt <= ecnt + 1;
  end
  always @(negedge clk) begin
    if (reset_n && ecnt % 4 == 1 && ecnt < 256) trace[ecnt / 4] = pm_addr;
  end

  // --------------------
  // Helpers
  // --------------------
  task automatic close_out();
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Hold reset and load a blank image; the program goes in before go
  task automatic start();
    @(posedge clk);
    reset_n <= 1'b0;
    rq <= '0;
    int_req <= 1'b0;
    slow <= 1'b0;
    for (int i = 0; i < 16384; i++) begin
      i_seq_far_memory.pmem[i] = {seq_pkg::OP_LOADI, 13'h0000};
    end
    for (int i = 0; i < 1024; i++) i_seq_far_memory.dmem[i] = 8'h00;
    repeat (19) @(posedge clk);
  endtask : start

  task automatic go();
    @(posedge clk);
    reset_n <= 1'b1;
  endtask : go

  task automatic cyc(input int n);
    repeat (4 * n) @(posedge clk);
  endtask : cyc

  task automatic p(input logic [13:0] a, input logic [2:0] op,
                   input logic [12:0] f);
    i_seq_far_memory.pmem[a] = {op, f};
  endtask : p

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    rq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    rq.wr <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    rq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    rq.rd <= 1'b0;
    #1 chk(16'(reg_rdata), 16'(exp));
  endtask : reg_rd

  // Bounded wait for a fetch address, then compare
  task automatic wait_pm(input logic [13:0] a, input int n);
    #1;
    for (int i = 0; i < n && pm_addr !== a; i++) @(posedge clk) #1;
    chk(16'(pm_addr), 16'(a));
  endtask : wait_pm

  // --------------------
  // Scenarios
  // --------------------
  task automatic t_fetch();
    start();
    go();
    repeat (4) @(posedge clk);
    #1 chk(16'(pm_addr), 16'h0000);
    @(posedge clk);
    #1 chk(16'(pm_addr), 16'h0001);
    cyc(2);
    chk(16'(trace[2]), 16'h0002);
  endtask : t_fetch

  // Add carries out to zero, increment lands in memory
  task automatic t_alu();
    start();
    i_seq_far_memory.dmem[10'h020] = 8'hAA;
    i_seq_far_memory.dmem[10'h021] = 8'h01;
    i_seq_far_memory.dmem[10'h022] = 8'h7F;
    p(14'h0000, seq_pkg::OP_LOADI, 13'h00FF);
    p(14'h0001, seq_pkg::OP_ALU, 13'h0021);
    p(14'h0002, seq_pkg::OP_STORE, 13'h0020);
    p(14'h0003, seq_pkg::OP_ALU, 13'h1522);
    p(14'h0004, seq_pkg::OP_GOTO, 13'h0004);
    go();
    cyc(10);
    for (int i = 0; i < 5; i++) chk(16'(trace[i]), 16'(i));
    chk(16'(i_seq_far_memory.dmem[10'h020]), 16'h0000);
    chk(16'(i_seq_far_memory.dmem[10'h022]), 16'h0080);
    reg_rd(seq_pkg::REG_STATUS, 8'h01);
    reg_rd(seq_pkg::REG_ACC, 8'h00);
  endtask : t_alu

  // Bank bit on: jump to the top word, then jump again with a dummy
  task automatic t_goto();
    start();
    p(14'h0000, seq_pkg::OP_GOTO, 13'h1FFF);
    p(14'h3FFF, seq_pkg::OP_GOTO, 13'h0005);
    go();
    reg_wr(seq_pkg::REG_CONTROL, 8'h02);
    cyc(6);
    chk(16'(trace[2]), 16'h3FFF);
    chk(16'(trace[4]), 16'h2005);
    chk(16'(trace[5]), 16'h2006);
  endtask : t_goto

  task automatic t_call();
    start();
    p(14'h0000, seq_pkg::OP_CALL, 13'h0100);
    p(14'h0001, seq_pkg::OP_LOADI, 13'h0077);
    p(14'h0002, seq_pkg::OP_STORE, 13'h0030);
    p(14'h0003, seq_pkg::OP_GOTO, 13'h0003);
    p(14'h0100, seq_pkg::OP_RET, 13'h0000);
    go();
    cyc(10);
    chk(16'(trace[2]), 16'h0100);
    chk(16'(trace[4]), 16'h0001);
    chk(16'(i_seq_far_memory.dmem[10'h030]), 16'h0077);
  endtask : t_call

  // Skip taken drops the prefetched load; not taken keeps it
  task automatic t_skip();
    for (int v = 0; v < 2; v++) begin
      start();
      i_seq_far_memory.dmem[10'h040] = 8'(v);
      p(14'h0000, seq_pkg::OP_LOADI, 13'h0033);
      p(14'h0001, seq_pkg::OP_SKZ, 13'h0040);
      p(14'h0002, seq_pkg::OP_LOADI, 13'h0011);
      p(14'h0003, seq_pkg::OP_STORE, 13'h0041);
      p(14'h0004, seq_pkg::OP_GOTO, 13'h0004);
      go();
      cyc(10);
      chk(16'(i_seq_far_memory.dmem[10'h041]), v ? 16'h11 : 16'h33);
    end
  endtask : t_skip

  task automatic t_pcl();
    start();
    p(14'h0000, seq_pkg::OP_GOTO, 13'h0205);
    go();
    cyc(4);
    reg_wr(seq_pkg::REG_PC_LOW, 8'hF0);
    wait_pm(14'h02F0, 40);
    cyc(1);
    #1 chk(16'(pm_addr), 16'h02F1);
    reg_rd(3'h7, 8'h00);
  endtask : t_pcl

  // Slow memory; high pointer bits above the address width are dropped
  task automatic t_table();
    start();
    slow <= 1'b1;
    i_seq_far_memory.pmem[14'h3F06] = 16'hA51A;
    p(14'h0002, seq_pkg::OP_TAB, 13'h0050);
    p(14'h0003, seq_pkg::OP_TAB, 13'h1150);
    p(14'h0004, seq_pkg::OP_GOTO, 13'h0004);
    go();
    reg_wr(seq_pkg::REG_TBL_LOW, 8'h06);
    reg_wr(seq_pkg::REG_TBL_HIGH, 8'hFF);
    cyc(10);
    chk(16'(trace[4]), 16'h3F06);
    chk(16'(trace[5]), 16'h0004);
    chk(16'(i_seq_far_memory.dmem[10'h050]), 16'h001A);
    chk(16'(i_seq_far_memory.dmem[10'h150]), 16'h001A);
    reg_rd(seq_pkg::REG_TBL_LATCH, 8'hA5);
    reg_rd(seq_pkg::REG_TBL_LOW, 8'h06);
  endtask : t_table

  task automatic t_int();
    start();
    p(14'h0000, seq_pkg::OP_GOTO, 13'h0100);
    p(14'h0004, seq_pkg::OP_RET, 13'h0001);
    go();
    reg_wr(seq_pkg::REG_CONTROL, 8'h01);
    cyc(4);
    @(posedge clk);
    int_req <= 1'b1;
    @(posedge clk);
    int_req <= 1'b0;
    wait_pm(14'h0004, 24);
    cyc(3);
    #1 chk(16'(pm_addr[13:8]), 16'h0001);
  endtask : t_int

  // Ninth call overflows; the interrupt waits until a return frees a level
  task automatic t_full();
    start();
    for (int k = 0; k < 8; k++) p(14'(k), seq_pkg::OP_CALL, 13'(k + 1));
    p(14'h0008, seq_pkg::OP_CALL, 13'h0020);
    p(14'h0030, seq_pkg::OP_RET, 13'h0000);
    go();
    reg_wr(seq_pkg::REG_CONTROL, 8'h01);
    wait_pm(14'h0020, 120);
    @(posedge clk);
    int_req <= 1'b1;
    @(posedge clk);
    int_req <= 1'b0;
    acked = 1'b0;
    for (int i = 0; i < 80 && pm_addr !== 14'h0030; i++) begin
      @(posedge clk) #1;
      acked = acked | int_ack;
    end
    chk(16'(acked), 16'h0000);
    for (int i = 0; i < 24 && int_ack !== 1'b1; i++) @(posedge clk) #1;
    chk(16'(int_ack), 16'h0001);
  endtask : t_full

  // Main sequence
  initial begin
    reset_n = 1'b0;
    int_req = 1'b0;
    slow = 1'b0;
    acked = 1'b0;
    rq = '0;
    bad_count = 0;
    num_checks = 0;
    t_fetch();
    t_alu();
    t_goto();
    t_call();
    t_skip();
    t_pcl();
    t_table();
    t_int();
    t_full();
    close_out();
  end

  // Watchdog: the whole run needs under a thousand clocks
  initial begin
    #50000;
    bad_count++;
    close_out();
  end
endmodule : test_mcu_program_sequencer
